// ==== src/abfo_core.sv ====
// Four-phase execution of AND-with-file, bit-clear, bit-set and bit-test-skip-if-clear.
`timescale 1ns/1ns
`default_nettype none
module abfo_core
  import abfo_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  input  wire logic [INSTR_W-1:0]   i_instr,
  input  wire logic                 i_instr_valid,
  input  wire logic [DATA_W-1:0]    i_file_rdata,
  input  wire logic                 i_work_we,
  input  wire logic [DATA_W-1:0]    i_work_wdata,
  output logic [ADDR_W-1:0]         o_file_addr,
  output abfo_file_wr_t             o_file_wr,
  output logic [DATA_W-1:0]         o_working_register,
  output logic                      o_zero_flag,
  output logic                      o_zero_we,
  output logic                      o_skip_active,
  output logic                      o_cycle_done,
  output abfo_phase_t               o_phase
);
  abfo_phase_t       phase;
  abfo_phase_t       next_phase;
  logic [INSTR_W-1:0] ir;
  logic [INSTR_W-1:0] next_ir;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] next_fval;
  logic [DATA_W-1:0] work;
  logic [DATA_W-1:0] next_work;
  logic              zflag;
  logic              next_zflag;
  logic              zwe;
  logic              next_zwe;
  logic              skip_pend;
  logic              next_skip_pend;
  logic              skip_cyc;
  logic              next_skip_cyc;
  abfo_file_wr_t     wr;
  abfo_file_wr_t     next_wr;
  logic              done;
  logic              next_done;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] ex_result;
  logic [DATA_W-1:0] next_ex_result;
  logic              is_and;
  logic              is_clr;
  logic              is_set;
  logic              is_tst;
  logic              tbit;

  abfo_alu u_alu (
    .i_instr  (ir),
    .i_file   (fval),
    .i_work   (work),
    .o_is_and (is_and),
    .o_is_clr (is_clr),
    .o_is_set (is_set),
    .o_is_tst (is_tst),
    .o_result (result),
    .o_bit    (tbit)
  );

  // Phase sequencer: one phase per clock, four clocks make one instruction cycle.
  // There is no stall input, so a cycle always takes exactly four clocks.
  always_comb begin
    case (phase)
      ABFO_Q1: begin
        next_phase = ABFO_Q2; // see [RULE9]
      end
      ABFO_Q2: begin
        next_phase = ABFO_Q3;
      end
      ABFO_Q3: begin
        next_phase = ABFO_Q4;
      end
      ABFO_Q4: begin
        next_phase = ABFO_Q1;
      end
      default: begin
        next_phase = ABFO_Q1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      phase <= ABFO_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Fetch and skip control: a taken test turns the next fetched word into a no-op.
  // The word is still accepted from the fetch side, so that side needs no extra handshake.
  always_comb begin
    next_ir        = ir;
    next_skip_pend = skip_pend;
    next_skip_cyc  = skip_cyc;
    if (phase == ABFO_Q1) begin
      // A skipped word is replaced by the no-op so it never reaches execute.
      if (skip_pend) begin
        next_ir        = NOP_WORD; // see [RULE7]
        next_skip_cyc  = 1'b1;
        next_skip_pend = 1'b0;
      end else if (i_instr_valid) begin
        next_ir       = i_instr;
        next_skip_cyc = 1'b0;
      end else begin
        next_ir       = NOP_WORD;
        next_skip_cyc = 1'b0;
      end
    end else if (phase == ABFO_Q4 && is_tst && !tbit) begin
      // Test costs one cycle, plus the forced no-op cycle when clear.
      next_skip_pend = 1'b1; // see [RULE6] [RULE8]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ir        <= NOP_WORD;
      skip_pend <= 1'b0;
      skip_cyc  <= 1'b0;
    end else begin
      ir        <= next_ir;
      skip_pend <= next_skip_pend;
      skip_cyc  <= next_skip_cyc;
    end
  end

  // Operand capture: the file byte is held from read to write, so a memory that
  // changes after the read cannot disturb the result.
  // Execute captures the result at the end of Q3, so Q4 only writes back.
  always_comb begin
    next_fval      = fval;
    next_ex_result = ex_result;
    if (phase == ABFO_Q2) begin
      next_fval = i_file_rdata;
    end
    if (phase == ABFO_Q3) begin
      next_ex_result = result; // see [RULE1] [RULE4] [RULE5]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      fval      <= 8'h00;
      ex_result <= 8'h00;
    end else begin
      fval      <= next_fval;
      ex_result <= next_ex_result;
    end
  end

  // Working register and zero flag; outside loads come in at phase one only,
  // so they settle before execute and never collide with the write-back.
  always_comb begin
    next_work  = work;
    next_zflag = zflag;
    next_zwe   = 1'b0;
    if (phase == ABFO_Q1 && i_work_we) begin
      next_work = i_work_wdata;
    end
    if (phase == ABFO_Q4 && is_and) begin
      next_zflag = (ex_result == 8'h00); // see [RULE1]
      next_zwe   = 1'b1;
      if (!ir[DEST_BIT]) begin
        next_work = ex_result; // see [RULE2]
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      work  <= WORK_RESET;
      zflag <= 1'b0;
      zwe   <= 1'b0;
    end else begin
      work  <= next_work;
      zflag <= next_zflag;
      zwe   <= next_zwe;
    end
  end

  // File write strobe and cycle end; both default low so each lasts one clock.
  // The address travels with the strobe, so the memory needs no latch of its own.
  always_comb begin
    next_wr   = '{addr: wr.addr, data: wr.data, we: 1'b0};
    next_done = 1'b0;
    if (phase == ABFO_Q4) begin
      if (is_and && ir[DEST_BIT]) begin
        next_wr = '{addr: ir[7:0], data: ex_result, we: 1'b1}; // see [RULE3]
      end else if (is_clr || is_set) begin
        next_wr = '{addr: ir[7:0], data: ex_result, we: 1'b1}; // see [RULE4] [RULE5]
      end
      next_done = 1'b1; // see [RULE9]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr   <= '0;
      done <= 1'b0;
    end else begin
      wr   <= next_wr;
      done <= next_done;
    end
  end

  always_comb begin
    o_file_addr        = ir[7:0];
    o_file_wr          = wr;
    o_working_register = work;
    o_zero_flag        = zflag;
    o_zero_we          = zwe;
    o_skip_active      = skip_cyc;
    o_cycle_done       = done;
    o_phase            = phase;
  end
endmodule // abfo_core
`default_nettype wire

// ==== src/abfo_pkg.sv ====
// Package with opcodes, phase encoding and the file-write carrier struct for the file-op execution block.
// What this block does
// [RULE1] AND-with-file ANDs working register and file, updates only zero flag.
// [RULE2] Destination bit 0 writes result to working register, file untouched.
// [RULE3] Destination bit 1 writes result to file, working register untouched.
// [RULE4] Bit-clear forces selected file bit to zero, others kept, flags unchanged.
// [RULE5] Bit-set forces selected file bit to one, others kept, flags unchanged.
// [RULE6] Bit-test reads selected bit; when zero the next instruction is skipped.
// [RULE7] On skip the fetched word is discarded and a forced no-op runs instead.
// [RULE8] Bit-test takes one cycle without skip, two when the skip is taken.
// [RULE9] AND, clear and set finish in one four-phase cycle: decode, read, execute, write.
package abfo_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam int          INSTR_W       = 16;
  localparam logic [6:0]  OPC_AND_HI    = 7'h05;
  localparam logic [4:0]  OPC_BCLR_HI   = 5'h11;
  localparam logic [4:0]  OPC_BSET_HI   = 5'h10;
  localparam logic [4:0]  OPC_BTSC_HI   = 5'h13;
  localparam int          DEST_BIT      = 8;
  localparam int          BIDX_LSB      = 8;
  localparam logic [7:0]  WORK_RESET    = 8'h00;
  localparam logic [15:0] NOP_WORD      = 16'h0000;

  typedef enum logic [1:0] {
    ABFO_Q1,
    ABFO_Q2,
    ABFO_Q3,
    ABFO_Q4
  } abfo_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              we;
  } abfo_file_wr_t;
endpackage

// ==== src/abfo_alu.sv ====
// Combinational execute stage for the four file-register operations.
`timescale 1ns/1ns
`default_nettype none
module abfo_alu
  import abfo_pkg::*;
(
  input  wire logic [INSTR_W-1:0] i_instr,
  input  wire logic [DATA_W-1:0]  i_file,
  input  wire logic [DATA_W-1:0]  i_work,
  output logic                    o_is_and,
  output logic                    o_is_clr,
  output logic                    o_is_set,
  output logic                    o_is_tst,
  output logic [DATA_W-1:0]       o_result,
  output logic                    o_bit
);
  logic [2:0]        bidx;
  logic [DATA_W-1:0] mask;

  always_comb begin
    bidx     = i_instr[BIDX_LSB+2:BIDX_LSB];
    mask     = 8'h01 << bidx;
    o_is_and = (i_instr[15:9] == OPC_AND_HI);
    o_is_clr = (i_instr[15:11] == OPC_BCLR_HI);
    o_is_set = (i_instr[15:11] == OPC_BSET_HI);
    o_is_tst = (i_instr[15:11] == OPC_BTSC_HI);
    o_bit    = i_file[bidx]; // see [RULE6]
    if (o_is_clr) begin
      o_result = i_file & ~mask; // see [RULE4]
    end else if (o_is_set) begin
      o_result = i_file | mask; // see [RULE5]
    end else begin
      o_result = i_work & i_file; // see [RULE1]
    end
  end
endmodule // abfo_alu
`default_nettype wire

// ==== tb/abfo_props.sv ====
// Checker for the file-op execution block.
`timescale 1ns/1ns
`default_nettype none
module abfo_props
  import abfo_pkg::*;
(
  input wire logic          i_clk_sys,
  input wire logic          i_reset,
  input wire logic [15:0]   i_instr,
  input wire logic [7:0]    i_file_rdata,
  input wire abfo_file_wr_t o_file_wr,
  input wire logic [7:0]    o_working_register,
  input wire logic          o_zero_flag,
  input wire logic          o_zero_we,
  input wire logic          o_skip_active,
  input wire logic          o_cycle_done,
  input wire abfo_phase_t   o_phase
);
  // Both hold until the result phase, so results line up with their cause.
  logic [15:0] w;
  logic [7:0]  d;
  logic [7:0]  m;
  always_ff @(posedge i_clk_sys) begin
    if (o_phase == ABFO_Q1) w <= i_instr;
    if (o_phase == ABFO_Q2) d <= i_file_rdata;
  end
  assign m = 8'h01 << w[10:8];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_nop;
    o_skip_active [*4] ##1 !o_skip_active;
  endsequence
  AST_AND: assert property (o_file_wr.we && w[15:9] == OPC_AND_HI |-> w[8] &&
    o_file_wr.addr == w[7:0] && o_file_wr.data == (d & $past(o_working_register)))
    else $error("and to file");
  AST_W: assert property (o_zero_we && !w[8] |-> !o_file_wr.we &&
    o_working_register == (d & $past(o_working_register))) else $error("and to w");
  AST_ZF: assert property (o_zero_we |-> w[15:9] == OPC_AND_HI &&
    o_zero_flag == ((d & $past(o_working_register)) == 8'h00)) else $error("zero");
  AST_CLR: assert property (o_file_wr.we && w[15:11] == OPC_BCLR_HI |->
    o_file_wr.data == (d & ~m)) else $error("clear");
  AST_SET: assert property (o_file_wr.we && w[15:11] == OPC_BSET_HI |->
    o_file_wr.data == (d | m)) else $error("set");
  AST_DONE: assert property (o_cycle_done |-> o_phase == ABFO_Q1 ##4 o_cycle_done)
    else $error("cycle");
  AST_SKIP: assert property (o_cycle_done && w[15:11] == OPC_BTSC_HI &&
    (d & m) == 8'h00 |=> s_nop) else $error("skip");
  AST_NOWR: assert property (o_skip_active && o_phase == ABFO_Q1 |->
    !o_file_wr.we && !o_zero_we) else $error("skipped word ran");
  AST_KEEP: assert property (o_cycle_done && w[15:11] == OPC_BTSC_HI &&
    (d & m) != 8'h00 |=> !o_skip_active) else $error("skip without cause");
endmodule // abfo_props
bind abfo_core abfo_props u_props (.i_clk_sys, .i_reset, .i_instr, .i_file_rdata, .o_file_wr,
  .o_working_register, .o_zero_flag, .o_zero_we, .o_skip_active, .o_cycle_done, .o_phase);
`default_nettype wire

// ==== tb/abfo_mem.sv ====
// Data memory model behind the core's file port.
`timescale 1ns/1ns
`default_nettype none
module abfo_mem
  import abfo_pkg::*;
(
  input  wire logic [7:0]    i_addr,
  input  wire logic          i_clk_sys,
  input  wire abfo_file_wr_t i_wr,
  output logic [7:0]         o_rdata
);
  logic [7:0] mem [256];
  assign o_rdata = mem[i_addr];
  always @(posedge i_clk_sys) begin
    if (i_wr.we) mem[i_wr.addr] <= i_wr.data;
  end
endmodule // abfo_mem
`default_nettype wire

// ==== tb/and_and_bit_file_ops_tb.sv ====
// Bench for the file-op execution block.
`timescale 1ns/1ns
`default_nettype none
module and_and_bit_file_ops_tb;
  import abfo_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [15:0]   ins = 16'h0000;
  logic [7:0]    rd, w, ad;
  abfo_file_wr_t wr;
  logic          zf, ze, sa, dn, sk;
  abfo_phase_t   ph;
  logic          vld = 1'b1;
  logic          wwe = 1'b0;
  logic [7:0]    wdat = 8'h00;
  int            fail_count = 0;
  int            comparisons = 0;
  always #50 clk = ~clk;
  abfo_core uut (.i_clk_sys(clk), .i_reset(rst), .i_instr(ins), .i_instr_valid(vld),
    .i_file_rdata(rd), .i_work_we(wwe), .i_work_wdata(wdat), .o_file_addr(ad),
    .o_file_wr(wr), .o_working_register(w), .o_zero_flag(zf), .o_zero_we(ze),
    .o_skip_active(sa), .o_cycle_done(dn), .o_phase(ph));
  abfo_mem u_mem (.i_addr(ad), .i_clk_sys(clk), .i_wr(wr), .o_rdata(rd));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Returns at the next phase one, the only cycle in which the strobes show.
  task automatic run(input logic [15:0] word);
    ins = word;
    @(negedge clk);
    wwe = 1'b0;
    sk = sa;
    repeat (3) @(negedge clk);
    chk("done", {dn, ph}, {1'b1, ABFO_Q1});
  endtask
  task automatic t_and();
    u_mem.mem[8'h05] = 8'hC2;
    u_mem.mem[8'h06] = 8'h40;
    wdat = 8'h17;
    wwe = 1'b1;
    run(16'h0B05);
    chk("and to file", wr, {8'h05, 8'h02, 1'b1});
    chk("and w", {w, ze, zf}, {8'h17, 2'b10});
    run(16'h0A05);
    chk("and to w", {w, ze, wr.we}, {8'h02, 2'b10});
    chk("and nonzero", zf, 1'b0);
    run(16'h0A06);
    chk("and zero", {w, ze, zf}, {8'h00, 2'b11});
  endtask
  task automatic t_bits();
    u_mem.mem[8'h10] = 8'hC7;
    run(16'h8F10);
    chk("clear", {wr, ze}, {8'h10, 8'h47, 2'b10});
    run(16'h8710);
    chk("set", {wr, ze}, {8'h10, 8'hC7, 2'b10});
  endtask
  task automatic t_skip();
    u_mem.mem[8'h30] = 8'hFD;
    u_mem.mem[8'h40] = 8'h00;
    run(16'h9930);
    chk("test", {ze, wr.we}, 2'b00);
    run(16'h8040);
    chk("skipped", {sk, wr.we}, 2'b10);
    run(16'h9830);
    run(16'h8040);
    chk("kept", {sk, wr}, {1'b0, 8'h40, 8'h01, 1'b1});
  endtask
  task automatic t_idle();
    vld = 1'b0;
    run(16'h0B05);
    vld = 1'b1;
    chk("idle", {wr.we, ze}, 2'b00);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_and();
    t_bits();
    t_skip();
    t_idle();
    stop_test();
  end
endmodule // and_and_bit_file_ops_tb
`default_nettype wire
